// file: hdl/port_pin_pkg.sv
// Constants and types shared by the port pin logic
package port_pin_pkg;
   // Glitch rejection for the two-wire inputs
   localparam int unsigned CLK_MHZ     = 200;
   localparam int unsigned GLITCH_NS   = 50;
   localparam int unsigned GLITCH_CYC  = (GLITCH_NS * CLK_MHZ) / 1000;

   localparam logic [1:0] SEL_SERIAL   = 2'h0;
   localparam logic [1:0] SEL_ONE      = 2'h1;
   localparam logic [1:0] SEL_TWO      = 2'h2;
   localparam logic [1:0] SEL_THREE    = 2'h3;

   localparam int unsigned ONE_LO      = 2;
   localparam int unsigned ONE_W       = 6;
   localparam logic [5:0] ONE_RST      = 6'h3f;
   localparam logic [7:0] TWO_RST      = 8'hff;
   localparam logic [7:0] THREE_RST    = 8'hff;
   localparam logic [1:0] SER_RST      = 2'h3;

   localparam int unsigned SER_CLK_BIT = 0;
   localparam int unsigned SER_DAT_BIT = 1;

   localparam int unsigned P3_RX       = 0;
   localparam int unsigned P3_TX       = 1;
   localparam int unsigned P3_IRQ0     = 2;
   localparam int unsigned P3_IRQ1     = 3;
   localparam int unsigned P3_TMR0     = 4;
   localparam int unsigned P3_TMR1     = 5;
   localparam int unsigned P3_WRS      = 6;
   localparam int unsigned P3_RDS      = 7;

   // Kind of instruction behind a port read
   typedef enum logic [3:0] {
      OP_PLAIN   = 4'h0,
      OP_ANL     = 4'h1,
      OP_ORL     = 4'h2,
      OP_XRL     = 4'h3,
      OP_JBC     = 4'h4,
      OP_CPL     = 4'h5,
      OP_INC     = 4'h6,
      OP_DEC     = 4'h7,
      OP_DJNZ    = 4'h8,
      OP_MOV_BIT = 4'h9,
      OP_CLR_BIT = 4'ha,
      OP_SET_BIT = 4'hb
   } op_kind_t;
endpackage : port_pin_pkg

// file: hdl/filt_if.sv
// Interface between the pin logic and one glitch filter
`timescale 1ns/1ps
interface filt_if;
   logic raw;
   logic clean;
   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface : filt_if

// file: hdl/glitch_filter.sv
// Rejects pulses up to a fixed number of cycles
`timescale 1ns/1ps
module glitch_filter #(
   parameter int unsigned REJECT_CYC = port_pin_pkg::GLITCH_CYC
) (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   filt_if.filt      f
);
   localparam int unsigned CW = $clog2(REJECT_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(REJECT_CYC);

   logic [CW-1:0] cnt_reg;
   logic          clean_reg;

   if (REJECT_CYC < 1) begin : g_chk
      $error("glitch_filter: REJECT_CYC must be at least 1");
   end

   // New level must outlast the reject window before it is passed on
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         cnt_reg   <= '0;
         clean_reg <= 1'b1;
      end
      else if (f.raw == clean_reg)
      begin
         cnt_reg <= '0;
      end
      else if (cnt_reg == LAST)
      begin
         cnt_reg   <= '0;
         clean_reg <= f.raw;
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   assign f.clean = clean_reg;
endmodule : glitch_filter

// file: hdl/port_pin_control.sv
// Port pin logic: ports one to three, serial pins and latch reads
//
// Notes on behaviour
// - Port one latch resets ones; zero gives digital input
// - Port one upper pins never drive
// - Port two emits address bytes during external access
// - Address mode drives push-pull; latch left unchanged
// - Port two latch one pulls up, zero drives low
// - Port three latch one pulls up, zero drives low
// - Alternate function only while latch is one
// - Port three bits map to fixed peripheral functions
// - Two-wire mode drops strong pull-up; SPI drives it
// - Two-wire mode enables both pull-downs, SPI one
// - Two-wire inputs reject pulses up to 50 ns
// - Master mode gives direct serial pin access
// - Slave select weak pull-up always on
// - Modify-type reads return the latch
// - Other reads return pin levels
// - Latch-read set is the listed instruction kinds
// - Bit instructions rewrite whole byte, one bit changed
`timescale 1ns/1ps
module port_pin_control (
   input  wire logic                  mclk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wr_i,
   input  wire logic [1:0]            wr_sel_i,
   input  wire logic [7:0]            wr_data_i,
   input  wire logic                  bit_wr_i,
   input  wire logic [2:0]            bit_idx_i,
   input  wire logic                  bit_val_i,
   input  wire logic                  rd_i,
   input  wire logic [1:0]            rd_sel_i,
   input  wire port_pin_pkg::op_kind_t rd_op_i,
   output logic      [7:0]            rd_data_o,
   output logic                       rd_valid_o,
   input  wire logic [5:0]            port_one_pin_i,
   output logic      [5:0]            port_one_analog_o,
   input  wire logic [7:0]            port_two_pin_i,
   output logic      [7:0]            port_two_out_o,
   output logic      [7:0]            port_two_oe_o,
   output logic      [7:0]            port_two_weak_up_o,
   input  wire logic                  ext_fetch_i,
   input  wire logic                  ext_data_i,
   input  wire logic                  ext_upper_i,
   input  wire logic [23:0]           ext_addr_i,
   input  wire logic [7:0]            port_three_pin_i,
   output logic      [7:0]            port_three_out_o,
   output logic      [7:0]            port_three_oe_o,
   output logic      [7:0]            port_three_weak_up_o,
   input  wire logic [7:0]            alt_out_i,
   output logic                       uart_rx_o,
   output logic                       ext_irq_zero_o,
   output logic                       ext_irq_one_o,
   output logic                       timer_zero_input_o,
   output logic                       pwm_external_clock_o,
   output logic                       timer_one_input_o,
   input  wire logic                  serial_mode_select_i,
   input  wire logic                  i2c_master_i,
   input  wire logic                  spi_clk_out_i,
   input  wire logic                  spi_clk_oe_i,
   input  wire logic                  spi_data_out_i,
   input  wire logic                  spi_data_oe_i,
   input  wire logic                  i2c_clk_out_i,
   input  wire logic                  i2c_data_out_i,
   input  wire logic                  serial_clock_pin_i,
   input  wire logic                  serial_data_pin_i,
   output logic                       serial_clock_strong_up_o,
   output logic      [1:0]            serial_clock_pull_dn_o,
   output logic                       serial_data_strong_up_o,
   output logic      [1:0]            serial_data_pull_dn_o,
   output logic                       spi_clk_in_o,
   output logic                       spi_data_in_o,
   output logic                       i2c_clk_in_o,
   output logic                       i2c_data_in_o,
   input  wire logic                  slave_sel_pin_n_i,
   output logic                       slave_sel_weak_up_o,
   output logic                       spi_slave_sel_n_o
);
   localparam int unsigned PW = 25;

   logic [5:0]    port_one_latch;
   logic [7:0]    port_two_latch;
   logic [7:0]    port_three_latch;
   logic [1:0]    ser_direct_reg;
   logic [PW-1:0] meta_reg;
   logic [PW-1:0] pin_reg;
   logic [7:0]    one_pins;
   logic [7:0]    two_pins;
   logic [7:0]    three_pins;
   logic [1:0]    ser_pins;
   logic [7:0]    latch_byte;
   logic [7:0]    pin_byte;
   logic [7:0]    bit_byte;
   logic          latch_read;
   logic          addr_mode;
   logic [7:0]    addr_byte;
   logic [7:0]    three_eff;
   logic          clk_val;
   logic          dat_val;

   filt_if f_ser [2] ();

   // Pins cross in through two flops before use
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '1;
         pin_reg  <= '1;
      end
      else
      begin
         meta_reg <= {slave_sel_pin_n_i, serial_data_pin_i, serial_clock_pin_i,
                      port_three_pin_i, port_two_pin_i, port_one_pin_i};
         pin_reg  <= meta_reg;
      end
   end

   assign one_pins   = {pin_reg[5:0], 2'h0};
   assign two_pins   = pin_reg[13:6];
   assign three_pins = pin_reg[21:14];
   assign ser_pins   = pin_reg[23:22];

   for (genvar g = 0; g < 2; g++)
   begin : g_filt
      assign f_ser[g].raw = ser_pins[g];
      glitch_filter u_filt (
         .mclk_i (mclk_i),
         .rst_i  (rst_i),
         .f      (f_ser[g].filt)
      );
   end

   always_comb
   begin
      unique case (wr_sel_i)
         port_pin_pkg::SEL_ONE:   latch_byte = {port_one_latch, 2'h0};
         port_pin_pkg::SEL_TWO:   latch_byte = port_two_latch;
         port_pin_pkg::SEL_THREE: latch_byte = port_three_latch;
         port_pin_pkg::SEL_SERIAL: latch_byte = {6'h00, ser_direct_reg};
      endcase
   end
   always_comb
   begin
      bit_byte            = latch_byte;
      bit_byte[bit_idx_i] = bit_val_i;
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         port_one_latch <= port_pin_pkg::ONE_RST;
      else if (wr_i && wr_sel_i == port_pin_pkg::SEL_ONE)
         port_one_latch <= wr_data_i[7:port_pin_pkg::ONE_LO];
      else if (bit_wr_i && wr_sel_i == port_pin_pkg::SEL_ONE)
         port_one_latch <= bit_byte[7:port_pin_pkg::ONE_LO];
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         port_two_latch <= port_pin_pkg::TWO_RST;
      else if (wr_i && wr_sel_i == port_pin_pkg::SEL_TWO)
         port_two_latch <= wr_data_i;
      else if (bit_wr_i && wr_sel_i == port_pin_pkg::SEL_TWO)
         port_two_latch <= bit_byte;
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         port_three_latch <= port_pin_pkg::THREE_RST;
      else if (wr_i && wr_sel_i == port_pin_pkg::SEL_THREE)
         port_three_latch <= wr_data_i;
      else if (bit_wr_i && wr_sel_i == port_pin_pkg::SEL_THREE)
         port_three_latch <= bit_byte;
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         ser_direct_reg <= port_pin_pkg::SER_RST;
      else if (wr_i && wr_sel_i == port_pin_pkg::SEL_SERIAL)
         ser_direct_reg <= wr_data_i[1:0];
      else if (bit_wr_i && wr_sel_i == port_pin_pkg::SEL_SERIAL)
         ser_direct_reg <= bit_byte[1:0];
   end
   assign latch_read = (rd_op_i != port_pin_pkg::OP_PLAIN);
   always_comb
   begin
      unique case (rd_sel_i)
         port_pin_pkg::SEL_ONE:   pin_byte = latch_read ?
                                     {port_one_latch, 2'h0} : one_pins;
         port_pin_pkg::SEL_TWO:   pin_byte = latch_read ? port_two_latch : two_pins;
         port_pin_pkg::SEL_THREE: pin_byte = latch_read ? port_three_latch : three_pins;
         port_pin_pkg::SEL_SERIAL: pin_byte = latch_read ?
                                     {6'h00, ser_direct_reg} : {6'h00, ser_pins};
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         rd_data_o  <= 8'h00;
         rd_valid_o <= 1'b0;
      end
      else
      begin
         rd_valid_o <= rd_i;
         if (rd_i)
            rd_data_o <= pin_byte;
      end
   end
   assign addr_mode = ext_fetch_i | ext_data_i;
   assign addr_byte = (ext_data_i && ext_upper_i) ? ext_addr_i[23:16] : ext_addr_i[15:8];

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         port_two_out_o     <= 8'h00;
         port_two_oe_o      <= 8'h00;
         port_two_weak_up_o <= 8'hff;
      end
      else if (addr_mode)
      begin
         port_two_out_o     <= addr_byte;
         port_two_oe_o      <= 8'hff;
         port_two_weak_up_o <= 8'h00;
      end
      else
      begin
         port_two_out_o     <= 8'h00;
         port_two_oe_o      <= ~port_two_latch;
         port_two_weak_up_o <= port_two_latch;
      end
   end
   // Port three: a zero latch holds the pin low over any function
   assign three_eff = port_three_latch & alt_out_i;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         port_three_out_o     <= 8'h00;
         port_three_oe_o      <= 8'h00;
         port_three_weak_up_o <= 8'hff;
      end
      else
      begin
         port_three_out_o     <= 8'h00;
         port_three_oe_o      <= ~three_eff;
         port_three_weak_up_o <= three_eff;
      end
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         uart_rx_o            <= 1'b1;
         ext_irq_zero_o       <= 1'b1;
         ext_irq_one_o        <= 1'b1;
         timer_zero_input_o   <= 1'b1;
         pwm_external_clock_o <= 1'b1;
         timer_one_input_o    <= 1'b1;
      end
      else
      begin
         uart_rx_o            <= three_pins[port_pin_pkg::P3_RX];
         ext_irq_zero_o       <= three_pins[port_pin_pkg::P3_IRQ0];
         ext_irq_one_o        <= three_pins[port_pin_pkg::P3_IRQ1];
         timer_zero_input_o   <= three_pins[port_pin_pkg::P3_TMR0];
         pwm_external_clock_o <= three_pins[port_pin_pkg::P3_TMR0];
         timer_one_input_o    <= three_pins[port_pin_pkg::P3_TMR1];
      end
   end
   assign clk_val = i2c_master_i ? ser_direct_reg[port_pin_pkg::SER_CLK_BIT]
                                 : i2c_clk_out_i;
   assign dat_val = i2c_master_i ? ser_direct_reg[port_pin_pkg::SER_DAT_BIT]
                                 : i2c_data_out_i;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         serial_clock_strong_up_o <= 1'b0;
         serial_clock_pull_dn_o   <= 2'h0;
         serial_data_strong_up_o  <= 1'b0;
         serial_data_pull_dn_o    <= 2'h0;
      end
      else if (serial_mode_select_i)
      begin
         serial_clock_strong_up_o <= spi_clk_oe_i & spi_clk_out_i;
         serial_clock_pull_dn_o   <= {1'b0, spi_clk_oe_i & ~spi_clk_out_i};
         serial_data_strong_up_o  <= spi_data_oe_i & spi_data_out_i;
         serial_data_pull_dn_o    <= {1'b0, spi_data_oe_i & ~spi_data_out_i};
      end
      else
      begin
         serial_clock_strong_up_o <= 1'b0;
         serial_clock_pull_dn_o   <= {2{~clk_val}};
         serial_data_strong_up_o  <= 1'b0;
         serial_data_pull_dn_o    <= {2{~dat_val}};
      end
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         spi_clk_in_o        <= 1'b1;
         spi_data_in_o       <= 1'b1;
         i2c_clk_in_o        <= 1'b1;
         i2c_data_in_o       <= 1'b1;
         spi_slave_sel_n_o   <= 1'b1;
         slave_sel_weak_up_o <= 1'b1;
      end
      else
      begin
         spi_clk_in_o        <= ser_pins[0];
         spi_data_in_o       <= ser_pins[1];
         i2c_clk_in_o        <= f_ser[0].clean;
         i2c_data_in_o       <= f_ser[1].clean;
         spi_slave_sel_n_o   <= pin_reg[24];
         slave_sel_weak_up_o <= 1'b1;
      end
   end
   // Port one pins have no driver; only the mode level leaves
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         port_one_analog_o <= port_pin_pkg::ONE_RST;
      else
         port_one_analog_o <= port_one_latch;
   end
endmodule : port_pin_control

// file: verif/port_pin_control_properties.sv
// Checker for the port pin control ports
`timescale 1ns/1ps
module port_pin_control_checker (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        wr_i,
   input wire logic [1:0]  wr_sel_i,
   input wire logic [7:0]  wr_data_i,
   input wire logic        rd_i,
   input wire logic        rd_valid_o,
   input wire logic [5:0]  port_one_analog_o,
   input wire logic [7:0]  port_two_out_o,
   input wire logic [7:0]  port_two_oe_o,
   input wire logic        ext_fetch_i,
   input wire logic        ext_data_i,
   input wire logic        ext_upper_i,
   input wire logic [23:0] ext_addr_i,
   input wire logic [7:0]  port_three_oe_o,
   input wire logic [7:0]  port_three_weak_up_o,
   input wire logic [7:0]  alt_out_i,
   input wire logic        serial_mode_select_i,
   input wire logic        i2c_master_i,
   input wire logic        spi_clk_out_i,
   input wire logic        spi_clk_oe_i,
   input wire logic        serial_clock_strong_up_o,
   input wire logic        serial_data_strong_up_o,
   input wire logic [1:0]  serial_clock_pull_dn_o,
   input wire logic [1:0]  serial_data_pull_dn_o,
   input wire logic        slave_sel_weak_up_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   property p_rd_valid;
      rd_i |=> rd_valid_o;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
   property p_one_latch;
      wr_i && wr_sel_i == port_pin_pkg::SEL_ONE
         |-> ##2 port_one_analog_o == $past(wr_data_i[7:2], 2);
   endproperty
   a_one_latch: assert property (p_one_latch) else $error("analog select wrong");
   property p_fetch;
      ext_fetch_i && !ext_data_i
         |=> port_two_oe_o == 8'hff && port_two_out_o == $past(ext_addr_i[15:8]);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch address wrong");
   property p_upper;
      ext_data_i && ext_upper_i
         |=> port_two_oe_o == 8'hff && port_two_out_o == $past(ext_addr_i[23:16]);
   endproperty
   a_upper: assert property (p_upper) else $error("upper address wrong");
   property p_three_alt;
      wr_i && wr_sel_i == port_pin_pkg::SEL_THREE
         |-> ##2 port_three_oe_o == ~($past(wr_data_i, 2) & $past(alt_out_i));
   endproperty
   a_three_alt: assert property (p_three_alt) else $error("port three drive wrong");
   property p_three_up;
      port_three_weak_up_o == ~port_three_oe_o;
   endproperty
   a_three_up: assert property (p_three_up) else $error("pull-up with drive");
   property p_i2c_up;
      !serial_mode_select_i |=> !serial_clock_strong_up_o && !serial_data_strong_up_o;
   endproperty
   a_i2c_up: assert property (p_i2c_up) else $error("strong pull-up in two-wire");
   property p_spi_up;
      serial_mode_select_i
         |=> serial_clock_strong_up_o == ($past(spi_clk_oe_i) && $past(spi_clk_out_i));
   endproperty
   a_spi_up: assert property (p_spi_up) else $error("spi pull-up wrong");
   property p_spi_dn;
      serial_mode_select_i |=> !serial_clock_pull_dn_o[1] && !serial_data_pull_dn_o[1];
   endproperty
   a_spi_dn: assert property (p_spi_dn) else $error("second pull-down in spi");
   property p_i2c_dn;
      !serial_mode_select_i |=> serial_clock_pull_dn_o[0] == serial_clock_pull_dn_o[1]
         && serial_data_pull_dn_o[0] == serial_data_pull_dn_o[1];
   endproperty
   a_i2c_dn: assert property (p_i2c_dn) else $error("pull-downs split");
   property p_direct;
      wr_i && wr_sel_i == port_pin_pkg::SEL_SERIAL ##1 (!serial_mode_select_i && i2c_master_i)
         |=> serial_data_pull_dn_o == {2{~$past(wr_data_i[1], 2)}};
   endproperty
   a_direct: assert property (p_direct) else $error("direct data drive wrong");
   property p_ss_up;
      slave_sel_weak_up_o;
   endproperty
   a_ss_up: assert property (p_ss_up) else $error("select pull-up off");
endmodule : port_pin_control_checker

bind port_pin_control port_pin_control_checker i_chk (.*);

// file: verif/pin_world.sv
// Pin-side model: pull-ups, external pull-downs, floating lines
`timescale 1ns/1ps
module pin_world (
   input  wire logic       mclk_i,
   input  wire logic [7:0] two_out_i,
   input  wire logic [7:0] two_oe_i,
   input  wire logic [7:0] two_up_i,
   input  wire logic [7:0] three_oe_i,
   input  wire logic [7:0] three_up_i,
   input  wire logic [7:0] two_low_i,
   input  wire logic [7:0] three_low_i,
   input  wire logic [1:0] clk_dn_i,
   input  wire logic [1:0] dat_dn_i,
   input  wire logic       dat_low_i,
   output logic      [7:0] two_pin_o,
   output logic      [7:0] three_pin_o,
   output logic            clk_pin_o,
   output logic            dat_pin_o
);
   logic tog_reg = 1'b0;
   // Unpulled lines wander so a stale level never reads back
   always @(posedge mclk_i) tog_reg <= ~tog_reg;
   always_comb
   begin
      for (int b = 0; b < 8; b++)
      begin
         two_pin_o[b] = two_oe_i[b] ? two_out_i[b] :
                        (two_low_i[b] ? 1'b0 : (two_up_i[b] ? 1'b1 : tog_reg));
         three_pin_o[b] = (three_oe_i[b] || three_low_i[b]) ? 1'b0 :
                          (three_up_i[b] ? 1'b1 : tog_reg);
      end
      clk_pin_o = !(|clk_dn_i);
      dat_pin_o = !(|dat_dn_i) && !dat_low_i;
   end
endmodule : pin_world

// file: verif/port_pin_control_tb.sv
// Self-checking bench for the port pin control
`timescale 1ns/1ps
module port_pin_control_tb;
   logic mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, bit_wr_i = 1'b0, rd_i = 1'b0, bit_val_i = 1'b0;
   logic ext_fetch_i = 1'b0, ext_data_i = 1'b0, ext_upper_i = 1'b0, dat_low = 1'b0;
   logic serial_mode_select_i = 1'b0, i2c_master_i = 1'b0, slave_sel_pin_n_i = 1'b1;
   logic spi_clk_out_i = 1'b0, spi_clk_oe_i = 1'b0, spi_data_out_i = 1'b0, spi_data_oe_i = 1'b0;
   logic i2c_clk_out_i = 1'b1, i2c_data_out_i = 1'b1;
   logic [1:0]  wr_sel_i = 2'h0, rd_sel_i = 2'h0;
   logic [2:0]  bit_idx_i = 3'h0;
   logic [7:0]  wr_data_i = 8'h00, alt_out_i = 8'hff, two_low = 8'h00, three_low = 8'h00;
   logic [23:0] ext_addr_i = 24'h000000;
   logic [5:0]  port_one_pin_i = 6'h00;
   port_pin_pkg::op_kind_t rd_op_i = port_pin_pkg::OP_PLAIN;
   logic [7:0]  rd_data_o, port_two_pin_i, port_two_out_o, port_two_oe_o, port_two_weak_up_o;
   logic [7:0]  port_three_pin_i, port_three_out_o, port_three_oe_o, port_three_weak_up_o;
   logic        rd_valid_o, uart_rx_o, ext_irq_zero_o, ext_irq_one_o, timer_zero_input_o;
   logic        pwm_external_clock_o, timer_one_input_o, serial_clock_pin_i, serial_data_pin_i;
   logic        serial_clock_strong_up_o, serial_data_strong_up_o, spi_clk_in_o, spi_data_in_o;
   logic        i2c_clk_in_o, i2c_data_in_o, slave_sel_weak_up_o, spi_slave_sel_n_o;
   logic [1:0]  serial_clock_pull_dn_o, serial_data_pull_dn_o;
   logic [5:0]  port_one_analog_o;
   int          failures = 0, comparisons = 0, cycles = 0;

   port_pin_control i_dut (.*);
   pin_world i_pins (.mclk_i(mclk_i), .two_out_i(port_two_out_o), .two_oe_i(port_two_oe_o),
      .two_up_i(port_two_weak_up_o), .three_oe_i(port_three_oe_o),
      .three_up_i(port_three_weak_up_o), .two_low_i(two_low), .three_low_i(three_low),
      .clk_dn_i(serial_clock_pull_dn_o), .dat_dn_i(serial_data_pull_dn_o), .dat_low_i(dat_low),
      .two_pin_o(port_two_pin_i), .three_pin_o(port_three_pin_i),
      .clk_pin_o(serial_clock_pin_i), .dat_pin_o(serial_data_pin_i));

   initial forever #2.5 mclk_i = ~mclk_i;

   task automatic end_sim;
      if (failures == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // Scenarios take a few hundred cycles
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         end_sim();
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick

   task automatic wr(input logic [1:0] sel, input logic [7:0] data);
      @(posedge mclk_i);
      wr_i <= 1'b1; wr_sel_i <= sel; wr_data_i <= data;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic bitwr(input logic [1:0] sel, input logic [2:0] idx, input logic val);
      @(posedge mclk_i);
      bit_wr_i <= 1'b1; wr_sel_i <= sel; bit_idx_i <= idx; bit_val_i <= val;
      @(posedge mclk_i);
      bit_wr_i <= 1'b0;
   endtask : bitwr

   task automatic rd(input logic [1:0] sel, input int op, output logic [7:0] data);
      @(posedge mclk_i);
      rd_i <= 1'b1; rd_sel_i <= sel; rd_op_i <= port_pin_pkg::op_kind_t'(op);
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk("rd_valid", 8'h01, {7'h00, rd_valid_o});
      data = rd_data_o;
   endtask : rd

   task automatic t_reset_one;
      logic [7:0] d;
      chk("one_analog", 8'h3f, {2'h0, port_one_analog_o});
      chk("two_up", 8'hff, port_two_weak_up_o);
      chk("three_up", 8'hff, port_three_weak_up_o);
      rd(port_pin_pkg::SEL_TWO, 1, d); chk("two_latch", 8'hff, d);
      @(posedge mclk_i) port_one_pin_i <= 6'h2a;
      wr(port_pin_pkg::SEL_ONE, 8'h0f); tick(1);
      chk("one_digital", 8'h03, {2'h0, port_one_analog_o});
      rd(port_pin_pkg::SEL_ONE, 2, d); chk("one_latch", 8'h0c, d);
      rd(port_pin_pkg::SEL_ONE, 0, d); chk("one_pins", 8'ha8, d);
      wr(port_pin_pkg::SEL_ONE, 8'hff);
   endtask : t_reset_one

   task automatic t_port_two;
      logic [7:0] d;
      @(posedge mclk_i) two_low <= 8'h01;
      wr(port_pin_pkg::SEL_TWO, 8'h0f); tick(1);
      chk("two_oe", 8'hf0, port_two_oe_o);
      chk("two_up", 8'h0f, port_two_weak_up_o);
      chk("two_out", 8'h00, port_two_out_o & port_two_oe_o);
      tick(3); rd(port_pin_pkg::SEL_TWO, 0, d); chk("two_pins", 8'h0e, d);
      rd(port_pin_pkg::SEL_TWO, 3, d); chk("two_latch", 8'h0f, d);
      @(posedge mclk_i) ext_fetch_i <= 1'b1; ext_addr_i <= 24'ha53c12;
      tick(1); chk("addr_oe", 8'hff, port_two_oe_o);
      chk("addr_high", 8'h3c, port_two_out_o);
      @(posedge mclk_i) ext_fetch_i <= 1'b0; ext_data_i <= 1'b1; ext_upper_i <= 1'b1;
      tick(1); chk("addr_top", 8'ha5, port_two_out_o);
      @(posedge mclk_i) ext_upper_i <= 1'b0;
      tick(1); chk("addr_mid", 8'h3c, port_two_out_o);
      @(posedge mclk_i) ext_data_i <= 1'b0; two_low <= 8'h00;
      tick(2); chk("two_back", 8'hf0, port_two_oe_o);
      rd(port_pin_pkg::SEL_TWO, 5, d); chk("two_kept", 8'h0f, d);
   endtask : t_port_two

   task automatic t_port_three;
      logic [7:0] p;
      wr(port_pin_pkg::SEL_THREE, 8'hf0); tick(1);
      chk("three_oe", 8'h0f, port_three_oe_o);
      @(posedge mclk_i) alt_out_i <= 8'h7e;
      tick(2); chk("three_alt", 8'h8f, port_three_oe_o);
      @(posedge mclk_i) alt_out_i <= 8'hff;
      wr(port_pin_pkg::SEL_THREE, 8'hff);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk_i) three_low <= 8'h01 << i;
         tick(4);
         p = ~(8'h01 << i);
         chk("alt_map", {2'h0, p[5], p[4], p[4], p[3], p[2], p[0]}, {2'h0, timer_one_input_o,
             pwm_external_clock_o, timer_zero_input_o, ext_irq_one_o, ext_irq_zero_o,
             uart_rx_o});
      end
   endtask : t_port_three

   task automatic t_latch_ops;
      logic [7:0] d;
      wr(port_pin_pkg::SEL_THREE, 8'h5a);
      @(posedge mclk_i) three_low <= 8'h42;
      tick(4);
      for (int k = 0; k < 12; k++)
      begin
         rd(port_pin_pkg::SEL_THREE, k, d); chk("op_read", (k == 0) ? 8'h18 : 8'h5a, d);
      end
      bitwr(port_pin_pkg::SEL_THREE, 3'h0, 1'b1);
      rd(port_pin_pkg::SEL_THREE, 10, d); chk("bit_set", 8'h5b, d);
      bitwr(port_pin_pkg::SEL_THREE, 3'h6, 1'b0);
      rd(port_pin_pkg::SEL_THREE, 9, d); chk("bit_clr", 8'h1b, d);
      @(posedge mclk_i) three_low <= 8'h00;
   endtask : t_latch_ops

   task automatic t_serial;
      logic [7:0] d;
      @(posedge mclk_i) serial_mode_select_i <= 1'b1; spi_clk_oe_i <= 1'b1;
      spi_clk_out_i <= 1'b1; spi_data_oe_i <= 1'b1; spi_data_out_i <= 1'b0;
      tick(2);
      chk("spi_up", 8'h02, {6'h0, serial_clock_strong_up_o, serial_data_strong_up_o});
      chk("spi_dn", 8'h01, {4'h0, serial_clock_pull_dn_o, serial_data_pull_dn_o});
      @(posedge mclk_i) serial_mode_select_i <= 1'b0; i2c_master_i <= 1'b1;
      wr(port_pin_pkg::SEL_SERIAL, 8'h02); tick(1);
      chk("i2c_up", 8'h00, {6'h0, serial_clock_strong_up_o, serial_data_strong_up_o});
      chk("i2c_dn", 8'h0c, {4'h0, serial_clock_pull_dn_o, serial_data_pull_dn_o});
      tick(4); rd(port_pin_pkg::SEL_SERIAL, 0, d); chk("direct", 8'h02, d & 8'h03);
      @(posedge mclk_i) slave_sel_pin_n_i <= 1'b0;
      tick(4);
      chk("ss_in", 8'h01, {5'h0, spi_slave_sel_n_o, spi_clk_in_o, spi_data_in_o});
      @(posedge mclk_i) slave_sel_pin_n_i <= 1'b1; i2c_master_i <= 1'b0;
   endtask : t_serial

   task automatic t_filter;
      logic seen;
      int   n;
      tick(20); chk("dat_idle", 8'h01, {7'h0, i2c_data_in_o});
      @(posedge mclk_i) dat_low <= 1'b1;
      repeat (10) @(posedge mclk_i);
      dat_low <= 1'b0;
      seen = 1'b1;
      repeat (30)
      begin
         tick(1);
         seen = seen & i2c_data_in_o;
      end
      chk("glitch", 8'h01, {7'h0, seen});
      @(posedge mclk_i) dat_low <= 1'b1;
      n = 0;
      while (i2c_data_in_o !== 1'b0 && n < 40)
      begin
         tick(1);
         n++;
      end
      chk("dat_low", 8'h00, {7'h0, i2c_data_in_o});
      chk("dat_delay", 8'h01, {7'h0, n > 10});
      @(posedge mclk_i) dat_low <= 1'b0;
   endtask : t_filter

   initial
   begin
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1;
      t_reset_one();
      t_port_two();
      t_port_three();
      t_latch_ops();
      t_serial();
      t_filter();
      end_sim();
   end
endmodule : port_pin_control_tb
